// ### common/abc_regs.svh
// Purpose: Register offsets, fields and reset values of the break unit
// Assumes: Byte-wide register port, offsets chosen locally
// Notes: Definitions only
`ifndef ABC_REGS_SVH
`define ABC_REGS_SVH
// Register offsets on the device register port
`define ABC_OFS_CTRL 3'h0
`define ABC_OFS_STAT 3'h1
`define ABC_OFS_ADDR_HI 3'h2
`define ABC_OFS_ADDR_LO 3'h3
`define ABC_OFS_DATA_HI 3'h4
`define ABC_OFS_DATA_LO 3'h5
// Control fields
`define ABC_CTRL_RTIE 7
`define ABC_CTRL_CSEL_HI 6
`define ABC_CTRL_CSEL_LO 5
`define ABC_CTRL_AMSK_HI 4
`define ABC_CTRL_AMSK_LO 2
`define ABC_CTRL_DSEL_HI 1
`define ABC_CTRL_DSEL_LO 0
// Status fields
`define ABC_STAT_FLAG 7
`define ABC_STAT_IEN 6
`define ABC_STAT_RSVD 6'h3F
// Reset values
`define ABC_CTRL_RST 8'h80
`define ABC_ADDR_RST 16'hFFFF
`define ABC_DATA_RST 16'h0000
`define ABC_BYTE_ZERO 8'h00
// Controller command register offsets (software side)
`define ABC_HOST_OFS_CMD 2'h0
`define ABC_HOST_OFS_ADDR 2'h1
`define ABC_HOST_OFS_WDATA 2'h2
`define ABC_HOST_OFS_STAT 2'h3
// Controller command bits
`define ABC_CMD_WRITE 0
`define ABC_CMD_READ 1
`endif

// ### common/abc_pkg.sv
// Purpose: Shared types of the break unit
// Assumes: Used with abc_regs.svh
// Notes: Types only
package abc_pkg;
	// Watched cycle type
	typedef enum logic [1:0] {
		ABC_CYC_EXEC = 2'h0,
		ABC_CYC_READ = 2'h1,
		ABC_CYC_WRITE = 2'h2,
		ABC_CYC_RDWR = 2'h3
	} abc_cyc_e;
	// Data lane compare select
	typedef enum logic [1:0] {
		ABC_DCMP_NONE = 2'h0,
		ABC_DCMP_LOW = 2'h1,
		ABC_DCMP_HIGH = 2'h2,
		ABC_DCMP_WORD = 2'h3
	} abc_dcmp_e;
	// Kind of space the bus cycle targets
	typedef enum logic [1:0] {
		ABC_SPC_MEM = 2'h0,
		ABC_SPC_IO8 = 2'h1,
		ABC_SPC_IO16 = 2'h2
	} abc_spc_e;
endpackage : abc_pkg

// ### common/abc_if.sv
// Purpose: Register port between controller and break unit
// Assumes: One clock, byte-wide register data
// Notes: Read data valid in the cycle after the read strobe
`timescale 1ns/1ns
interface abc_if;
	logic [2:0] reg_addr; // Register offset
	logic [7:0] reg_wdata; // Write data
	logic reg_wr; // Write strobe
	logic reg_rd; // Read strobe
	logic [7:0] reg_rdata; // Read data, one cycle after strobe
	// Break unit end
	modport dev (
		input reg_addr,
		input reg_wdata,
		input reg_wr,
		input reg_rd,
		output reg_rdata
	);
	// Controller end
	modport host (
		output reg_addr,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		input reg_rdata
	);
endinterface : abc_if

// ### src/abc_lane_cmp.sv
// Purpose: Compare one byte lane against a reference under a select
// Assumes: Combinational
// Notes: Instantiated once per lane
`timescale 1ns/1ns
module abc_lane_cmp #(
	parameter int W = 8
) (
	// Operands
	input wire logic [W-1:0] lane,
	input wire logic [W-1:0] ref_val,
	// Lane takes part
	input wire logic used,
	// Result
	output logic ok
);
	// Pass when unused, else exact equality
	assign ok = !used || (lane == ref_val);
endmodule : abc_lane_cmp

// ### src/abc_dev.sv
// Purpose: Address break comparator watching the CPU internal buses
// Assumes: Inputs synchronous to ref_clk; one bus cycle per valid pulse
// Notes: Request goes to the CPU beside its interrupt mask, not through it
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "abc_regs.svh"
module abc_dev #(
	parameter int AW = 16,
	parameter int DW = 16
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Register port
	abc_if.dev rbus,
	// CPU bus cycle
	input wire logic cyc_valid,
	input wire logic cyc_fetch,
	input wire logic cyc_write,
	input wire logic cyc_word,
	input wire abc_pkg::abc_spc_e cyc_space,
	input wire logic [AW-1:0] cyc_addr,
	input wire logic [DW-1:0] cyc_data,
	// CPU instruction sequencing
	input wire logic insn_done,
	input wire logic insn_is_rte,
	// Interrupt outputs
	output logic brk_irq,
	output logic rte_hold
);
	logic [7:0] ctrl_ff; // Control register
	logic flag_ff; // Break flag
	logic ien_ff; // Break enable
	logic flag_seen_ff; // Flag read as one since last clear
	logic [AW-1:0] addr_ff; // Break address
	logic [DW-1:0] data_ff; // Break data
	logic [7:0] rdata_ff; // Registered read data
	logic rte_hold_ff; // Mask window after return
	logic [AW-1:0] amask; // Address compare mask
	logic type_hit; // Cycle type matches
	logic addr_hit; // Address matches
	logic use_hi, use_lo; // Lanes compared
	logic hi_ok, lo_ok; // Lane results
	logic hit; // Full match
	logic [1:0] csel; // Cycle select
	logic [1:0] dsel; // Data select
	logic [2:0] asel; // Address mask select
	logic upper_lane; // Transfer rides upper lane
	logic wr_stat; // Status write
	logic rd_stat; // Status read

	assign csel = ctrl_ff[`ABC_CTRL_CSEL_HI:`ABC_CTRL_CSEL_LO];
	assign dsel = ctrl_ff[`ABC_CTRL_DSEL_HI:`ABC_CTRL_DSEL_LO];
	assign asel = ctrl_ff[`ABC_CTRL_AMSK_HI:`ABC_CTRL_AMSK_LO];
	assign wr_stat = rbus.reg_wr && (rbus.reg_addr == `ABC_OFS_STAT);
	assign rd_stat = rbus.reg_rd && (rbus.reg_addr == `ABC_OFS_STAT);

	// Cycle type selection
	always_comb
	begin
		unique case (abc_pkg::abc_cyc_e'(csel))
			abc_pkg::ABC_CYC_EXEC: type_hit = cyc_fetch;
			abc_pkg::ABC_CYC_READ: type_hit = !cyc_fetch && !cyc_write;
			abc_pkg::ABC_CYC_WRITE: type_hit = !cyc_fetch && cyc_write;
			abc_pkg::ABC_CYC_RDWR: type_hit = !cyc_fetch;
		endcase
	end

	// Address mask width; reserved codes left to software
	always_comb
	begin
		unique case (asel[1:0])
			2'h0: amask = {AW{1'b1}};
			2'h1: amask = {AW{1'b1}} << (AW / 4);
			2'h2: amask = {AW{1'b1}} << (AW / 2);
			2'h3: amask = {AW{1'b1}} << (3 * AW / 4);
		endcase
	end
	assign addr_hit = ((cyc_addr ^ addr_ff) & amask) == '0;

	// Byte lane actually carrying the transfer
	always_comb
	begin
		if (!cyc_word || cyc_space == abc_pkg::ABC_SPC_IO8)
			upper_lane = 1'b1;
		else
			upper_lane = !cyc_addr[0];
	end

	// Lanes that take part in the data check
	always_comb
	begin
		unique case (abc_pkg::abc_dcmp_e'(dsel))
			abc_pkg::ABC_DCMP_NONE:
			begin
				use_hi = 1'b0;
				use_lo = 1'b0;
			end
			abc_pkg::ABC_DCMP_LOW:
			begin
				use_hi = 1'b0;
				use_lo = 1'b1;
			end
			abc_pkg::ABC_DCMP_HIGH:
			begin
				use_hi = 1'b1;
				use_lo = 1'b0;
			end
			abc_pkg::ABC_DCMP_WORD:
			begin
				use_hi = 1'b1;
				use_lo = 1'b1;
			end
		endcase
	end

	// Upper lane against high data byte
	abc_lane_cmp #(.W(DW / 2)) u_hi (
		.lane(cyc_data[DW-1:DW/2]),
		.ref_val(data_ff[DW-1:DW/2]),
		.used(use_hi),
		.ok(hi_ok)
	);

	// Lower lane against low data byte
	abc_lane_cmp #(.W(DW / 2)) u_lo (
		.lane(cyc_data[DW/2-1:0]),
		.ref_val(data_ff[DW/2-1:0]),
		.used(use_lo),
		.ok(lo_ok)
	);

	// Exec cycles ignore data; byte lane must be the one in use
	assign hit = cyc_valid && type_hit && addr_hit && (cyc_fetch ||
		(hi_ok && lo_ok && !(use_hi && !use_lo && !upper_lane) &&
		!(use_lo && !use_hi && upper_lane)));

	// Control register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_ff <= `ABC_CTRL_RST;
		else if (clk_en && rbus.reg_wr && rbus.reg_addr == `ABC_OFS_CTRL)
			ctrl_ff <= rbus.reg_wdata;
	end

	// Break enable bit
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			ien_ff <= 1'b0;
		else if (clk_en && wr_stat)
			ien_ff <= rbus.reg_wdata[`ABC_STAT_IEN];
	end

	// Break flag: set wins, clear needs earlier read of one
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			flag_ff <= 1'b0;
		else if (clk_en)
		begin
			if (hit)
				flag_ff <= 1'b1;
			else if (wr_stat && !rbus.reg_wdata[`ABC_STAT_FLAG] &&
				flag_seen_ff)
				flag_ff <= 1'b0;
		end
	end

	// Read-as-one tracker for flag clearing
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			flag_seen_ff <= 1'b0;
		else if (clk_en)
		begin
			if (rd_stat && flag_ff)
				flag_seen_ff <= 1'b1;
			else if (wr_stat && !rbus.reg_wdata[`ABC_STAT_FLAG])
				flag_seen_ff <= 1'b0;
		end
	end

	// Break address and data registers
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			addr_ff <= AW'(`ABC_ADDR_RST);
			data_ff <= DW'(`ABC_DATA_RST);
		end
		else if (clk_en && rbus.reg_wr)
		begin
			// Byte writes into each half
			unique case (rbus.reg_addr)
				`ABC_OFS_ADDR_HI: addr_ff[AW-1:AW/2] <= rbus.reg_wdata;
				`ABC_OFS_ADDR_LO: addr_ff[AW/2-1:0] <= rbus.reg_wdata;
				`ABC_OFS_DATA_HI: data_ff[DW-1:DW/2] <= rbus.reg_wdata;
				`ABC_OFS_DATA_LO: data_ff[DW/2-1:0] <= rbus.reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_ff <= `ABC_BYTE_ZERO;
		else if (clk_en)
		begin
			if (!rbus.reg_rd)
				rdata_ff <= `ABC_BYTE_ZERO;
			else
			begin
				unique case (rbus.reg_addr)
					`ABC_OFS_CTRL: rdata_ff <= ctrl_ff;
					`ABC_OFS_STAT: rdata_ff <= {flag_ff, ien_ff,
						`ABC_STAT_RSVD};
					`ABC_OFS_ADDR_HI: rdata_ff <= addr_ff[AW-1:AW/2];
					`ABC_OFS_ADDR_LO: rdata_ff <= addr_ff[AW/2-1:0];
					`ABC_OFS_DATA_HI: rdata_ff <= data_ff[DW-1:DW/2];
					`ABC_OFS_DATA_LO: rdata_ff <= data_ff[DW/2-1:0];
					default: rdata_ff <= `ABC_BYTE_ZERO;
				endcase
			end
		end
	end
	assign rbus.reg_rdata = rdata_ff;

	// Mask window after return from exception
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rte_hold_ff <= 1'b0;
		else if (clk_en && insn_done)
			rte_hold_ff <= insn_is_rte && !ctrl_ff[`ABC_CTRL_RTIE];
	end
	assign rte_hold = rte_hold_ff;

	// Request to CPU, independent of its mask bit
	assign brk_irq = flag_ff && ien_ff;
endmodule : abc_dev

// ### src/abc_host.sv
// Purpose: Controller that drives the break unit register port
// Assumes: Software issues one command at a time
// Notes: Address and write data held in local registers; command gives one-cycle strobes
`timescale 1ns/1ns
`include "abc_regs.svh"
module abc_host (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Software port
	input wire logic [1:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [7:0] sw_rdata,
	// Device port
	abc_if.host rbus
);
	logic [2:0] tgt_ff; // Target device offset
	logic [7:0] wdata_ff; // Data to write
	logic [7:0] result_ff; // Last device read result
	logic wr_ff, rd_ff; // Strobes to device
	logic pend_ff; // Read answer due
	logic [7:0] sw_rdata_ff; // Software read data

	// Target and data registers loaded from the software port
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tgt_ff <= 3'h0;
			wdata_ff <= `ABC_BYTE_ZERO;
		end
		else if (clk_en && sw_wr)
		begin
			if (sw_addr == `ABC_HOST_OFS_ADDR)
				tgt_ff <= sw_wdata[2:0];
			else if (sw_addr == `ABC_HOST_OFS_WDATA)
				wdata_ff <= sw_wdata;
		end
	end

	// One-cycle strobes from the command register
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_ff <= sw_wr && sw_addr == `ABC_HOST_OFS_CMD &&
				sw_wdata[`ABC_CMD_WRITE];
			rd_ff <= sw_wr && sw_addr == `ABC_HOST_OFS_CMD &&
				!sw_wdata[`ABC_CMD_WRITE] && sw_wdata[`ABC_CMD_READ];
		end
	end

	// Capture the device answer
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend_ff <= 1'b0;
			result_ff <= `ABC_BYTE_ZERO;
		end
		else if (clk_en)
		begin
			pend_ff <= rd_ff;
			if (pend_ff)
				result_ff <= rbus.reg_rdata;
		end
	end

	// Software read data
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			sw_rdata_ff <= `ABC_BYTE_ZERO;
		else if (clk_en)
		begin
			if (!sw_rd)
				sw_rdata_ff <= `ABC_BYTE_ZERO;
			else
			begin
				unique case (sw_addr)
					`ABC_HOST_OFS_CMD: sw_rdata_ff <= {6'h00, pend_ff, rd_ff};
					`ABC_HOST_OFS_ADDR: sw_rdata_ff <= {5'h00, tgt_ff};
					`ABC_HOST_OFS_WDATA: sw_rdata_ff <= wdata_ff;
					`ABC_HOST_OFS_STAT: sw_rdata_ff <= result_ff;
				endcase
			end
		end
	end
	assign sw_rdata = sw_rdata_ff;

	// Device port drive
	assign rbus.reg_addr = tgt_ff;
	assign rbus.reg_wdata = wdata_ff;
	assign rbus.reg_wr = wr_ff && clk_en;
	assign rbus.reg_rd = rd_ff && clk_en;
endmodule : abc_host

// ### test/abc_assertions.sv
// Purpose: Register port checks of the break unit
// Assumes: Strobes already gated by clk_en, so frozen cycles look idle
// Notes: Fed from the joined register port
`timescale 1ns/1ns
module abc_assertions (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// Written since reset: status, address high, control
	logic [2:0] seen_ff;
	// Marks first writes
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn)
			seen_ff <= 3'h0;
		else if (reg_wr)
			seen_ff <= seen_ff | {reg_addr == 3'h1, reg_addr == 3'h2,
				reg_addr == 3'h0};
	a_rsvd_ones: assert property (
		reg_rd && reg_addr == 3'h1 |=> reg_rdata[5:0] == 6'h3F)
		else $error("status low bits not ones");
	a_en_reset: assert property (
		reg_rd && reg_addr == 3'h1 && !seen_ff[2] |=> !reg_rdata[6])
		else $error("enable not clear after reset");
	a_ctrl_reset: assert property (
		reg_rd && reg_addr == 3'h0 && !seen_ff[0] |=> reg_rdata == 8'h80)
		else $error("control reset value wrong");
	a_addr_reset: assert property (
		reg_rd && reg_addr == 3'h2 && !seen_ff[1] |=> reg_rdata == 8'hFF)
		else $error("address reset value wrong");
	a_ctrl_rback: assert property (
		reg_wr && reg_addr == 3'h0 ##1 !reg_wr [*2] ##1
		reg_rd && reg_addr == 3'h0 |=> reg_rdata == $past(reg_wdata, 4))
		else $error("control readback wrong");
	a_addr_rback: assert property (
		reg_wr && reg_addr inside {3'h2, 3'h3} ##1 !reg_wr [*2] ##1
		reg_rd && reg_addr == $past(reg_addr, 3)
		|=> reg_rdata == $past(reg_wdata, 4))
		else $error("address readback wrong");
	a_data_rback: assert property (
		reg_wr && reg_addr inside {3'h4, 3'h5} ##1 !reg_wr [*2] ##1
		reg_rd && reg_addr == $past(reg_addr, 3)
		|=> reg_rdata == $past(reg_wdata, 4))
		else $error("data readback wrong");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr[2:1] == 2'h3 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without strobe");
endmodule : abc_assertions

// ### test/tb_top.sv
// Purpose: Self-checking bench of controller and break unit
// Assumes: clk_en high except in the frozen-enable case
// Notes: Register readback first, then table of bus cycles, hand cases after
`timescale 1ns/1ns
module tb_top;
	// Stimulus and observed signals
	logic ref_clk, resetn, clk_en, sw_wr, sw_rd;
	logic [1:0] sw_addr;
	logic [7:0] sw_wdata, sw_rdata, v;
	logic cyc_valid, cyc_fetch, cyc_write, cyc_word;
	abc_pkg::abc_spc_e cyc_space;
	logic [15:0] cyc_addr, cyc_data;
	logic insn_done, insn_is_rte, brk_irq, rte_hold;
	int bad_count, checks;
	// Rows: control, flags, space, address, data, hit
	logic [51:0] rows [19];
	// Offset and value pairs
	logic [15:0] prs [6];
	abc_if abc_if_i ();
	abc_host abc_host_i (.ref_clk, .resetn, .clk_en, .sw_addr,
		.sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .rbus(abc_if_i));
	abc_dev abc_dev_i (.ref_clk, .resetn, .clk_en, .rbus(abc_if_i),
		.cyc_valid, .cyc_fetch, .cyc_write, .cyc_word, .cyc_space,
		.cyc_addr, .cyc_data, .insn_done, .insn_is_rte, .brk_irq,
		.rte_hold);
	abc_assertions abc_assertions_i (.ref_clk, .resetn,
		.reg_addr(abc_if_i.reg_addr), .reg_wdata(abc_if_i.reg_wdata),
		.reg_wr(abc_if_i.reg_wr), .reg_rd(abc_if_i.reg_rd),
		.reg_rdata(abc_if_i.reg_rdata));
	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Compare and count
	task chk(input logic [7:0] got, input logic [7:0] want);
		checks++;
		if (got !== want)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk
	// One software port cycle
	task sw(input logic [1:0] a, input logic [7:0] d, input logic w, r);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= w;
		sw_rd <= r;
		@(posedge ref_clk);
	endtask : sw
	// Device register write through the controller
	task dev_wr(input logic [7:0] o, input logic [7:0] d);
		sw(2'h1, o, 1'b1, 1'b0);
		sw(2'h2, d, 1'b1, 1'b0);
		sw(2'h0, 8'h01, 1'b1, 1'b0);
		sw(2'h0, 8'h00, 1'b0, 1'b0);
	endtask : dev_wr
	// Device register read, result into v
	task dev_rd(input logic [7:0] o);
		sw(2'h1, o, 1'b1, 1'b0);
		sw(2'h0, 8'h02, 1'b1, 1'b0);
		repeat (3) sw(2'h0, 8'h00, 1'b0, 1'b0);
		sw(2'h3, 8'h00, 1'b0, 1'b1);
		// Drop the strobe at the edge, then take the standing answer
		sw_rd <= 1'b0;
		sw_addr <= 2'h0;
		#1 v = sw_rdata;
		@(posedge ref_clk);
	endtask : dev_rd
	// One CPU bus clock
	task cpu(input logic vl, input logic [39:0] c);
		cyc_valid <= vl;
		{cyc_fetch, cyc_write, cyc_word} <= c[39:37];
		cyc_space <= abc_pkg::abc_spc_e'(c[33:32]);
		{cyc_addr, cyc_data} <= c[31:0];
		@(posedge ref_clk);
	endtask : cpu
	// One instruction boundary
	task ins(input logic dn, input logic rt);
		insn_done <= dn;
		insn_is_rte <= rt;
		@(posedge ref_clk);
	endtask : ins
	// Counts, verdict, end
	task close_out;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	// Watchdog: run needs about 500 cycles
	initial
	begin
		#100000;
		bad_count++;
		close_out();
	end
	// Main sequence
	initial
	begin
		rows = '{52'h80_8_0_1234_0000_1, 52'h80_8_0_1235_0000_0,
			52'hA4_0_0_123F_0000_1, 52'hA4_4_0_1234_0000_0,
			52'hC8_4_0_12FF_0000_1, 52'hEC_0_0_1FFF_0000_1,
			52'hEC_4_0_2234_0000_0, 52'hEC_8_0_1234_0000_0,
			52'hA2_0_0_1234_A500_1, 52'hA6_0_0_1235_A500_1,
			52'hA6_0_0_1234_00A5_0, 52'hA5_2_0_1235_005A_1,
			52'hA5_2_0_1234_5A5A_0, 52'hA6_2_2_1234_A500_1,
			52'hA6_2_1_1235_A500_1, 52'hA3_2_0_1234_A55A_1,
			52'hA3_2_0_1234_A55B_0, 52'hA3_2_0_1236_A55A_0,
			52'h83_8_0_1234_0000_1};
		prs = '{16'h0212, 16'h0334, 16'h04A5, 16'h055A, 16'h002D,
			16'h0140};
		resetn = 1'b0;
		clk_en = 1'b1;
		{sw_wr, sw_rd, sw_addr, sw_wdata} = 12'h000;
		{cyc_valid, cyc_fetch, cyc_write, cyc_word} = 4'h0;
		cyc_space = abc_pkg::ABC_SPC_MEM;
		{cyc_addr, cyc_data, insn_done, insn_is_rte} = 34'h0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		// Load and read back registers
		for (int k = 0; k < 6; k++)
		begin
			dev_wr(prs[k][15:8], prs[k][7:0]);
			dev_rd(prs[k][15:8]);
			chk(v, prs[k][7:0] | {2'h0, {6{k == 5}}});
		end
		$display("test done: setup");
		// Table of bus cycles
		for (int i = 0; i < 19; i++)
		begin
			dev_wr(8'h00, rows[i][51:44]);
			cpu(1'b1, rows[i][43:4]);
			cpu(1'b0, rows[i][43:4]);
			chk({7'h00, brk_irq}, {7'h00, rows[i][0]});
			dev_rd(8'h01);
			chk(v, {rows[i][0], 7'h7F});
			dev_wr(8'h01, 8'h40);
		end
		$display("test done: table");
		// Flag with enable off, clear without read
		dev_wr(8'h00, 8'h80);
		dev_wr(8'h01, 8'h00);
		cpu(1'b1, 40'h8012340000);
		cpu(1'b0, 40'h8012340000);
		chk({7'h00, brk_irq}, 8'h00);
		dev_wr(8'h01, 8'h00);
		dev_wr(8'h01, 8'h40);
		// Let the enable write settle before looking at the request
		sw(2'h0, 8'h00, 1'b0, 1'b0);
		chk({7'h00, brk_irq}, 8'h01);
		dev_rd(8'h01);
		chk(v, 8'hFF);
		dev_wr(8'h01, 8'h40);
		dev_rd(8'h01);
		chk(v, 8'h7F);
		$display("test done: flag");
		// Hold after return, then no hold
		dev_wr(8'h00, 8'h00);
		ins(1'b1, 1'b1);
		ins(1'b0, 1'b0);
		chk({7'h00, rte_hold}, 8'h01);
		ins(1'b1, 1'b0);
		ins(1'b0, 1'b0);
		chk({7'h00, rte_hold}, 8'h00);
		dev_wr(8'h00, 8'h80);
		ins(1'b1, 1'b1);
		ins(1'b0, 1'b0);
		chk({7'h00, rte_hold}, 8'h00);
		$display("test done: return");
		// Frozen clock enable must drop a matching exec cycle
		clk_en <= 1'b0;
		cpu(1'b1, 40'h8012340000);
		cpu(1'b0, 40'h8012340000);
		clk_en <= 1'b1;
		chk({7'h00, brk_irq}, 8'h00);
		dev_rd(8'h01);
		chk(v, 8'h7F);
		$display("test done: enable");
		// Second reset, reset values, unmapped place
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		dev_wr(8'h06, 8'hAA);
		prs = '{16'h0080, 16'h02FF, 16'h03FF, 16'h013F, 16'h0600,
			16'h0700};
		for (int k = 0; k < 6; k++)
		begin
			dev_rd(prs[k][15:8]);
			chk(v, prs[k][7:0]);
		end
		$display("test done: reset");
		close_out();
	end
endmodule : tb_top
